// ===== include/pbsp_buf_if.sv
// handshake carrier between the port and its write buffer
`timescale 1ns/1ps
`default_nettype none
interface pbsp_buf_if #(
  parameter int W = 8
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  // entries in age order, 0 is the oldest
  logic [1:0] ent_valid;
  logic [W-1:0] ent_data [2];

  modport src (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data, ent_valid, ent_data
  );
  modport store (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data, ent_valid, ent_data
  );
endinterface
`default_nettype wire

// ===== include/pbsp_pkg.sv
// constants and types for the pipelined burst memory port
// ==========================================================
// How it works
// - low two address bits wrap 11 to 00
// - synchronous inputs captured on rising clock edge
// - each byte enable gates its byte and parity
// - any sampled byte enable low tristates outputs
// - chip select examined only on address loads
// - output enable gates drivers without clocking
// - advance low steps counter, high holds address
// - cpu strobe with select loads address, reads
// - ctrl strobe loads address, writes if enabled
// - ctrl strobe without select powers down
// - continue or suspend cycles write or read
// - reads drive stored data when output enabled
// - outputs stay high impedance from power up
// - read after write presents just written data
// - idle after write shows written bytes once
// - two bit burst counter, clocked output register
`default_nettype none
package pbsp_pkg;

  // ==========================================================
  // geometry
  localparam int PBSP_ADDR_W = 16;
  localparam int PBSP_LANES = 2;
  localparam int PBSP_BYTE_W = 8;
  localparam int PBSP_LANE_W = PBSP_BYTE_W + 1;
  localparam int PBSP_WORD_W = PBSP_LANES * PBSP_LANE_W;
  localparam int PBSP_BURST_W = 2;
  localparam logic [PBSP_BURST_W-1:0] PBSP_BURST_STEP = 2'h1;
  localparam int PBSP_BUF_DEPTH = 2;

  // write buffer entry: {address, lane data, lane mask}
  localparam int PBSP_ENT_MASK_LSB = 0;
  localparam int PBSP_ENT_DATA_LSB = PBSP_LANES;
  localparam int PBSP_ENT_ADDR_LSB = PBSP_LANES + PBSP_WORD_W;

  // ==========================================================
  // reset values
  localparam logic [PBSP_ADDR_W-1:0] PBSP_ADDR_RST = 16'h0000;
  localparam logic [PBSP_WORD_W-1:0] PBSP_WORD_RST = 18'h00000;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    PBSP_ST_DOWN   = 2'b01,
    PBSP_ST_ACTIVE = 2'b10
  } pbsp_state_t;

  typedef enum logic [2:0] {
    PBSP_OP_NONE  = 3'b001,
    PBSP_OP_READ  = 3'b010,
    PBSP_OP_WRITE = 3'b100
  } pbsp_op_t;

endpackage
`default_nettype wire

// ===== rtl/pbsp_buf2.sv
// two-entry write buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pbsp_buf2 (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // buffer ports
  pbsp_buf_if.store bq
);
  localparam int W = $bits(bq.in_data);

  logic [W-1:0] slot [2];
  logic [1:0] count;
  logic rd_ptr;
  logic wr_ptr;
  logic push;
  logic pop;

  assign bq.in_ready = (count != 2'h2);
  assign bq.out_valid = (count != 2'h0);
  assign bq.out_data = slot[rd_ptr];
  assign push = bq.in_valid & bq.in_ready;
  assign pop = bq.out_valid & bq.out_ready;

  assign bq.ent_valid[0] = (count != 2'h0);
  assign bq.ent_valid[1] = (count == 2'h2);
  assign bq.ent_data[0] = slot[rd_ptr];
  assign bq.ent_data[1] = slot[~rd_ptr];

  // ==========================================================
  // pointers and occupancy
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end

  // ==========================================================
  // storage
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      slot[0] <= '0;
      slot[1] <= '0;
    end else if (push) begin
      slot[wr_ptr] <= bq.in_data;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/pbsp_sram_port.sv
// pipelined burst static memory with its synchronous host port
`timescale 1ns/1ps
`default_nettype none
module pbsp_sram_port
  import pbsp_pkg::*;
#(
  parameter int ADDR_W = PBSP_ADDR_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // address and strobes
  input wire logic [ADDR_W-1:0] word_addr_in,
  input wire logic chip_sel_n,
  input wire logic cpu_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  // byte write enables
  input wire logic low_byte_write_en_n,
  input wire logic high_byte_write_en_n,
  // output enable, not clocked
  input wire logic out_en_n,
  // data pins
  input wire logic [2*PBSP_BYTE_W-1:0] data_in,
  output logic [2*PBSP_BYTE_W-1:0] data_out,
  output logic [2*PBSP_BYTE_W-1:0] data_oe,
  // parity pins
  input wire logic low_parity_in,
  output logic low_parity_out,
  output logic low_parity_oe,
  input wire logic high_parity_in,
  output logic high_parity_out,
  output logic high_parity_oe,
  // write buffer acceptance
  output logic write_accept
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int ENT_W = ADDR_W + PBSP_WORD_W + PBSP_LANES;

  // ==========================================================
  // registered access state
  pbsp_state_t state;
  pbsp_state_t next_state;
  pbsp_op_t op;
  pbsp_op_t next_op;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [PBSP_LANES-1:0] wmask;
  logic [PBSP_WORD_W-1:0] wdata;

  logic [PBSP_LANES-1:0] we_sampled;
  logic any_we;
  logic deselect;
  logic hold_off;
  logic [PBSP_WORD_W-1:0] pin_word;
  wire logic [PBSP_WORD_W-1:0] q_word;
  wire logic [PBSP_LANES-1:0] drive;
  logic [1:0] hit;

  // lane 0 is the low byte with its parity, lane 1 the high
  assign we_sampled = {~high_byte_write_en_n, ~low_byte_write_en_n};
  assign any_we = |we_sampled;
  assign pin_word = {high_parity_in, data_in[15:8],
                     low_parity_in, data_in[7:0]};

  // ==========================================================
  // write buffer
  pbsp_buf_if #(.W(ENT_W)) bq ();

  pbsp_buf2 u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .bq(bq)
  );

  // ==========================================================
  // cycle decode
  always_comb begin
    next_state = state;
    next_op = PBSP_OP_NONE;
    next_addr = addr;
    deselect = 1'b0;
    if (!cpu_addr_strobe_n && !chip_sel_n) begin
      // cpu strobe always starts a read, enables ignored
      next_state = PBSP_ST_ACTIVE;
      next_op = PBSP_OP_READ;
      next_addr = word_addr_in;
    end else if (!ctrl_addr_strobe_n && !chip_sel_n) begin
      next_state = PBSP_ST_ACTIVE;
      next_addr = word_addr_in;
      next_op = any_we ? PBSP_OP_WRITE : PBSP_OP_READ;
    end else if (!ctrl_addr_strobe_n && chip_sel_n) begin
      next_state = PBSP_ST_DOWN;
      deselect = 1'b1;
    end else begin
      // select is not looked at here
      case (state)
        PBSP_ST_ACTIVE: begin
          if (!burst_advance_n) begin
            next_addr = {addr[ADDR_W-1:PBSP_BURST_W],
                         addr[PBSP_BURST_W-1:0] + PBSP_BURST_STEP};
          end
          // advance high keeps the loaded address for a write
          next_op = any_we ? PBSP_OP_WRITE : PBSP_OP_READ;
        end
        PBSP_ST_DOWN: begin
          next_op = PBSP_OP_NONE;
        end
        default: begin
          next_op = PBSP_OP_NONE;
        end
      endcase
    end
  end

  // ==========================================================
  // capture on the rising edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= PBSP_ST_DOWN;
      op <= PBSP_OP_NONE;
      addr <= PBSP_ADDR_RST;
    end else begin
      state <= next_state;
      op <= next_op;
      addr <= next_addr;
    end
  end

  // write data and lanes registered for pass-through
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wmask <= '0;
      wdata <= PBSP_WORD_RST;
    end else if (next_op == PBSP_OP_WRITE) begin
      wmask <= we_sampled;
      wdata <= pin_word;
    end else begin
      wmask <= '0;
    end
  end

  // ==========================================================
  // buffer fill and drain
  // fill happens at the edge that samples the write
  assign bq.in_valid = (next_op == PBSP_OP_WRITE);
  assign bq.in_data = {next_addr, pin_word, we_sampled};
  // drain yields the array to a read in progress
  assign bq.out_ready = (op != PBSP_OP_READ);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      write_accept <= 1'b1;
    end else begin
      write_accept <= bq.in_ready;
    end
  end

  // buffered writes that match the read address
  always_comb begin
    hit = 2'b00;
    for (int e = 0; e < 2; e++) begin
      if (bq.ent_valid[e] &&
          bq.ent_data[e][PBSP_ENT_ADDR_LSB +: ADDR_W] == addr) begin
        hit[e] = 1'b1;
      end
    end
  end

  // an enable sampled low, or deselect, blanks the drivers
  assign hold_off = any_we | deselect;

  // ==========================================================
  // per lane array, forwarding and output register
  for (genvar l = 0; l < PBSP_LANES; l++) begin : g_lane
    logic [PBSP_LANE_W-1:0] cells [DEPTH];
    logic [PBSP_LANE_W-1:0] rd;
    logic [ADDR_W-1:0] d_addr;
    logic [PBSP_LANE_W-1:0] d_lane;
    logic d_en;
    logic [PBSP_LANE_W-1:0] q_lane;
    logic drv;

    assign d_addr = bq.out_data[PBSP_ENT_ADDR_LSB +: ADDR_W];
    assign d_lane =
      bq.out_data[PBSP_ENT_DATA_LSB + l*PBSP_LANE_W +: PBSP_LANE_W];
    assign d_en = bq.out_valid & bq.out_ready &
                  bq.out_data[PBSP_ENT_MASK_LSB + l];

    // only the enabled lane is written
    always_ff @(posedge clk) begin
      if (d_en) begin
        cells[d_addr] <= d_lane;
      end
    end

    // newer buffered data overrides the array
    always_comb begin
      rd = cells[addr];
      for (int e = 0; e < 2; e++) begin
        if (hit[e] && bq.ent_data[e][PBSP_ENT_MASK_LSB + l]) begin
          rd = bq.ent_data[e][PBSP_ENT_DATA_LSB + l*PBSP_LANE_W +:
                              PBSP_LANE_W];
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_b) begin
        q_lane <= '0;
        drv <= 1'b0;
      end else begin
        case (op)
          PBSP_OP_READ: begin
            q_lane <= rd;
            drv <= 1'b1;
          end
          PBSP_OP_WRITE: begin
            q_lane <= wdata[l*PBSP_LANE_W +: PBSP_LANE_W];
            drv <= wmask[l];
          end
          default: begin
            drv <= 1'b0;
          end
        endcase
        if (hold_off) begin
          drv <= 1'b0;
        end
      end
    end

    // each lane owns one slice of the output register
    assign q_word[l*PBSP_LANE_W +: PBSP_LANE_W] = q_lane;
    assign drive[l] = drv;
  end

  // ==========================================================
  // pins
  assign data_out = {q_word[16:9], q_word[7:0]};
  assign low_parity_out = q_word[8];
  assign high_parity_out = q_word[17];

  // output enable acts directly on the drivers
  // controller keeps it high around write data
  assign data_oe = {{PBSP_BYTE_W{drive[1] & ~out_en_n}},
                    {PBSP_BYTE_W{drive[0] & ~out_en_n}}};
  assign low_parity_oe = drive[0] & ~out_en_n;
  assign high_parity_oe = drive[1] & ~out_en_n;
endmodule
`default_nettype wire

// ===== verification/pbsp_ctrl_model.sv
// cache controller model driving the burst memory port
`timescale 1ns/1ps
`default_nettype none
module pbsp_ctrl_model (
  // address and strobes
  output logic [15:0] word_addr_in,
  output logic chip_sel_n,
  output logic cpu_addr_strobe_n,
  output logic ctrl_addr_strobe_n,
  output logic burst_advance_n,
  // enables
  output logic low_byte_write_en_n,
  output logic high_byte_write_en_n,
  output logic out_en_n,
  // write data
  output logic [15:0] data_in,
  output logic low_parity_in,
  output logic high_parity_in
);
  logic prev_cpu = 1'b0;
  // kind 0 cpu strobe, 1 ctrl strobe, 2 none
  task automatic cyc(input logic [1:0] kind, input logic [15:0] a,
    input logic [1:0] we_n, input logic adv_n, input logic sel_n,
    input logic ctl_n, input logic [17:0] d);
    logic wr;
    wr = we_n != 2'h3;
    word_addr_in = a;
    chip_sel_n = sel_n;
    cpu_addr_strobe_n = kind != 2'h0;
    ctrl_addr_strobe_n = kind == 2'h0 ? ctl_n : kind != 2'h1;
    burst_advance_n = adv_n | (prev_cpu & wr);
    {high_byte_write_en_n, low_byte_write_en_n} = we_n;
    out_en_n = wr;
    if (wr) begin
      {high_parity_in, data_in[15:8], low_parity_in, data_in[7:0]} = d;
    end else begin
      // released bus: toggle so stale data cannot pass
      {high_parity_in, low_parity_in, data_in} =
        ~{high_parity_in, low_parity_in, data_in};
    end
    prev_cpu = kind == 2'h0 && !sel_n;
  endtask
endmodule
`default_nettype wire

// ===== verification/pbsp_sram_port_props.sv
// assertion checker for the burst memory port
`timescale 1ns/1ps
`default_nettype none
module pbsp_sram_port_props
  import pbsp_pkg::*;
#(
  parameter int ADDR_W = PBSP_ADDR_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // controls
  input wire logic [ADDR_W-1:0] word_addr_in,
  input wire logic chip_sel_n,
  input wire logic cpu_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic low_byte_write_en_n,
  input wire logic high_byte_write_en_n,
  input wire logic out_en_n,
  // data lanes
  input wire logic [2*PBSP_BYTE_W-1:0] data_in,
  input wire logic [2*PBSP_BYTE_W-1:0] data_out,
  input wire logic [2*PBSP_BYTE_W-1:0] data_oe,
  input wire logic low_parity_in,
  input wire logic low_parity_out,
  input wire logic low_parity_oe,
  input wire logic high_parity_in,
  input wire logic high_parity_out,
  input wire logic high_parity_oe,
  input wire logic write_accept
);
  wire logic we = !low_byte_write_en_n || !high_byte_write_en_n;
  wire logic desel = !ctrl_addr_strobe_n && chip_sel_n;
  wire logic keep = !we && !desel;
  wire logic idle = cpu_addr_strobe_n && ctrl_addr_strobe_n;
  wire logic ld = !ctrl_addr_strobe_n && !chip_sel_n && cpu_addr_strobe_n;
  wire logic drv_off = data_oe == '0 && !low_parity_oe && !high_parity_oe;
  wire logic drv_on = &data_oe && low_parity_oe && high_parity_oe;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  we_off_a: assert property (we |=> drv_off)
    else $error("drive after byte enable");
  oe_gate_a: assert property (out_en_n |-> drv_off)
    else $error("drive with output disabled");
  desel_off_a: assert property (desel |=> drv_off)
    else $error("drive after deselect");
  lane_pair_a: assert property (
    data_oe == {{8{high_parity_oe}}, {8{low_parity_oe}}})
    else $error("lane drive split");
  cpu_read_a: assert property (
    (!cpu_addr_strobe_n && !chip_sel_n) ##1 keep ##1 !out_en_n |-> drv_on)
    else $error("cpu read not driven");
  sel_skip_a: assert property (
    (ld && !we) ##1 (idle && chip_sel_n && !we) ##1 keep ##1 !out_en_n
    |-> drv_on) else $error("continue read lost");
  pass_low_a: assert property (
    (ld && !low_byte_write_en_n && high_byte_write_en_n) ##1 (idle && !we)
    ##1 !out_en_n |-> data_oe == 16'h00ff &&
    low_parity_out == $past(low_parity_in, 2) &&
    (data_out & 16'h00ff) == ($past(data_in, 2) & 16'h00ff))
    else $error("one byte pass-through wrong");
  pass_high_a: assert property (
    (ld && low_byte_write_en_n && !high_byte_write_en_n) ##1 (idle && !we)
    ##1 !out_en_n |-> data_oe == 16'hff00 && !low_parity_oe &&
    high_parity_out == $past(high_parity_in, 2) &&
    (data_out & 16'hff00) == ($past(data_in, 2) & 16'hff00))
    else $error("high byte pass-through wrong");
  accept_room_a: assert property (write_accept)
    else $error("write buffer refused a word");
  rw_pass_a: assert property (
    (ld && !low_byte_write_en_n && !high_byte_write_en_n) ##1
    (!cpu_addr_strobe_n && !chip_sel_n && !we) ##1 !out_en_n
    |-> drv_on && data_out == $past(data_in, 2))
    else $error("read after write lost data");
  rst_quiet_a: assert property (
    disable iff (1'b0) !rst_b |=> drv_off) else $error("drive in reset");
endmodule

bind pbsp_sram_port pbsp_sram_port_props #(.ADDR_W(ADDR_W))
  u_pbsp_sram_port_props (
  .clk, .rst_b, .word_addr_in, .chip_sel_n, .cpu_addr_strobe_n,
  .ctrl_addr_strobe_n, .burst_advance_n, .low_byte_write_en_n,
  .high_byte_write_en_n, .out_en_n, .data_in, .data_out, .data_oe,
  .low_parity_in, .low_parity_out, .low_parity_oe, .high_parity_in,
  .high_parity_out, .high_parity_oe, .write_accept
);
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the burst memory port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk;
  logic rst_b;
  wire logic [15:0] word_addr_in, data_in, data_out, data_oe;
  wire logic chip_sel_n, cpu_addr_strobe_n, ctrl_addr_strobe_n;
  wire logic burst_advance_n, low_byte_write_en_n, high_byte_write_en_n;
  wire logic out_en_n, low_parity_in, low_parity_out, low_parity_oe;
  wire logic high_parity_in, high_parity_out, high_parity_oe, write_accept;
  wire logic [17:0] q = {high_parity_out, data_out[15:8], low_parity_out,
    data_out[7:0]};
  int n_mismatch = 0;
  int compares = 0;
  logic [31:0] seed = 32'hae801558;
  logic [17:0] mem [16];
  logic act = 1'h0;
  logic [15:0] cur = 16'h0;
  logic [1:0] p_m = 2'h0;
  logic [1:0] e_m = 2'h0;
  logic [17:0] p_d = 18'h0;
  logic [17:0] e_d = 18'h0;

  pbsp_sram_port u_pbsp_sram_port (
    .clk, .rst_b, .word_addr_in, .chip_sel_n, .cpu_addr_strobe_n,
    .ctrl_addr_strobe_n, .burst_advance_n, .low_byte_write_en_n,
    .high_byte_write_en_n, .out_en_n, .data_in, .data_out, .data_oe,
    .low_parity_in, .low_parity_out, .low_parity_oe, .high_parity_in,
    .high_parity_out, .high_parity_oe, .write_accept
  );
  pbsp_ctrl_model u_pbsp_ctrl_model (
    .word_addr_in, .chip_sel_n, .cpu_addr_strobe_n, .ctrl_addr_strobe_n,
    .burst_advance_n, .low_byte_write_en_n, .high_byte_write_en_n,
    .out_en_n, .data_in, .low_parity_in, .high_parity_in
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [15:0] nxt(input logic [15:0] a, input logic n);
    return n ? a : {a[15:2], a[1:0] + 2'h1};
  endfunction
  function automatic logic [17:0] lm(input logic [1:0] m);
    return {{9{m[1]}}, {9{m[0]}}};
  endfunction

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one bus cycle: check what the last but one cycle left, then drive
  task automatic step(input logic [1:0] kind, input logic [15:0] a,
    input logic [1:0] we_n, input logic adv_n, input logic sel_n,
    input logic [17:0] d);
    logic ld, v, wr;
    logic [1:0] m;
    @(negedge clk);
    chk({16'h0, high_parity_oe, low_parity_oe}, {16'h0, e_m});
    chk(q & lm(e_m), e_d & lm(e_m));
    chk({17'h0, write_accept}, 18'h1);
    u_pbsp_ctrl_model.cyc(kind, a, we_n, adv_n, sel_n, seed[18] | sel_n, d);
    ld = !sel_n && kind != 2'h2;
    v = ld || (act && !(kind == 2'h1 && sel_n));
    wr = v && we_n != 2'h3 && !(ld && kind == 2'h0);
    cur = ld ? a : nxt(cur, u_pbsp_ctrl_model.burst_advance_n);
    m = wr ? ~we_n : 2'h3;
    e_m = (we_n != 2'h3 || (kind == 2'h1 && sel_n)) ? 2'h0 : p_m;
    e_d = p_d;
    if (wr) begin
      mem[cur[3:0]] = (mem[cur[3:0]] & ~lm(m)) | (d & lm(m));
    end
    p_m = v ? m : 2'h0;
    p_d = wr ? d : mem[cur[3:0]];
    act = v;
  endtask

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (8000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end

  initial begin
    rst_b = 1'h0;
    u_pbsp_ctrl_model.cyc(2'h2, 16'h0, 2'h0, 1'h1, 1'h1, 1'h1, 18'h0);
    repeat (20) @(negedge clk);
    rst_b = 1'h1;
    step(2'h2, 16'h0, 2'h3, 1'h1, 1'h1, 18'h0);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      step(2'h1, {12'hc35, i[3:0]}, 2'h0, 1'h1, 1'h0, seed[17:0]);
    end
    // deselect, then a continue that must find the port asleep
    step(2'h1, 16'h0, 2'h3, 1'h1, 1'h1, 18'h0);
    step(2'h2, 16'h0, 2'h3, 1'h0, 1'h0, 18'h0);
    repeat (3000) begin
      seed = xs(seed);
      step(seed[1] ? 2'h2 : {1'h0, seed[0]}, {12'hc35, seed[5:2]},
        seed[6] ? 2'h3 : seed[8:7], seed[9], seed[10] & seed[11],
        seed[31:14]);
    end
    step(2'h2, 16'h0, 2'h3, 1'h1, 1'h1, 18'h0);
    step(2'h2, 16'h0, 2'h3, 1'h1, 1'h1, 18'h0);
    end_sim;
  end
endmodule
`default_nettype wire
